// >>> pkg/mpcd_pkg.sv
// Constants and carrier types for the master interrupt controller command port decode
package mpcd_pkg;

    localparam logic [7:0] CMD_PORT_ADDR = 8'h20;
    localparam logic [7:0] DATA_PORT_ADDR = 8'h21;

    // Command and data port byte layout
    localparam int INIT_SEL_BIT = 4;
    localparam int OCW_SEL_BIT = 3;
    localparam int POLL_BIT = 2;
    localparam int SMM_HI = 6;
    localparam int SMM_LO = 5;
    localparam int RSEL_HI = 1;
    localparam int RSEL_LO = 0;
    localparam int EOI_HI = 7;
    localparam int EOI_LO = 5;
    localparam int LVL_HI = 2;
    localparam int LVL_LO = 0;
    localparam int VBASE_HI = 7;
    localparam int VBASE_LO = 3;
    localparam int SINGLE_CONTROLLER_FLAG_BIT = 1;
    localparam int IC4_BIT = 0;
    localparam int POLL_ANY_BIT = 7;

    localparam logic [1:0] SMM_CLEAR = 2'h2;
    localparam logic [1:0] SMM_SET = 2'h3;
    localparam logic [1:0] RSEL_REQ = 2'h2;
    localparam logic [1:0] RSEL_ISR = 2'h3;

    localparam logic [2:0] EOI_AEOI_ROT_CLR = 3'h0;
    localparam logic [2:0] EOI_NONSPEC = 3'h1;
    localparam logic [2:0] EOI_NOP = 3'h2;
    localparam logic [2:0] EOI_SPECIFIC = 3'h3;
    localparam logic [2:0] EOI_AEOI_ROT_SET = 3'h4;
    localparam logic [2:0] EOI_ROT_NONSPEC = 3'h5;
    localparam logic [2:0] EOI_SET_PRIO = 3'h6;
    localparam logic [2:0] EOI_ROT_SPECIFIC = 3'h7;

    localparam logic [4:0] RST_VBASE = 5'h00;
    localparam logic [7:0] RST_WORD = 8'h00;

    typedef enum logic [3:0] {
        ST_READY = 4'h1,
        ST_W2 = 4'h2,
        ST_W3 = 4'h4,
        ST_W4 = 4'h8
    } mpcd_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mpcd_bus_t;

    typedef struct packed {
        logic valid;
        logic nonspec;
        logic specific;
        logic rotate;
        logic set_prio;
        logic [2:0] level;
    } mpcd_eoi_t;

    typedef struct packed {
        mpcd_state_t state;
        logic init_done;
        logic [7:0] first_word;
        logic [4:0] vbase;
        logic [7:0] third_word;
        logic [7:0] fourth_word;
        logic special_mask;
        logic rsel_isr;
        logic poll;
        logic aeoi_rotate;
        mpcd_eoi_t eoi;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] vector;
    } mpcd_regs_t;

endpackage

// >>> src/mpcd_vec_form.sv
// Vector and poll byte former for the master interrupt controller
`timescale 1ns/1ps
module mpcd_vec_form #(
    parameter int N_LEVELS = 8
) (
    input wire logic [4:0] i_vbase,
    input wire logic [2:0] i_level,
    input wire logic [N_LEVELS-1:0] i_request,
    output logic [7:0] o_vector,
    output logic [7:0] o_poll_byte
);

    generate
        if (N_LEVELS != 8)
        begin : g_bad_levels
            $error("mpcd_vec_form serves exactly eight levels");
        end
    endgenerate

    logic [2:0] top_level;

    assign o_vector = {i_vbase, i_level};

    // Fixed priority, level 0 highest; rotation is resolved elsewhere
    always_comb
    begin
        top_level = 3'h0;
        for (int i = N_LEVELS - 1; i >= 0; i--)
        begin
            if (i_request[i])
            begin
                top_level = i[2:0];
            end
        end
    end

    assign o_poll_byte = {|i_request, 4'h0, top_level};

endmodule // mpcd_vec_form

// >>> src/mpcd_top.sv
// Command and data port decode of the master interrupt controller
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Special mask field 10 clears, 11 sets, 00 and 01 leave special mask.
// - Command write with bit 4 set is the first initialization word.
// - Command write with bit 4 clear, bit 3 set updates mask-and-poll word.
// - Command write with bits 4 and 3 clear is the EOI/priority word.
// - Bit 2 of the mask-and-poll word arms a poll; zero means no poll.
// - Read-select 10 returns request register, 11 in-service register next.
// - Read-select 00 or 01 keeps the previously selected status register.
// - Vector is five-bit base in bits 7-3 above the level in 2-0.
// - First initialization word resets state and rewinds the word pointer.
// - Each data port write during initialization loads the current word and advances the pointer; in ready it does nothing.
// - Pointer skips the third word when the single-controller flag is 1.
// - Pointer skips the fourth word when the fourth-word-needed flag is 0.
// - EOI field 001 nonspecific, 011 specific, 101 rotate on nonspecific.
// - EOI level field picks level 0 to 7 for specific or priority commands.
module mpcd_top #(
    parameter int N_LEVELS = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire mpcd_pkg::mpcd_bus_t i_bus,
    input wire logic [N_LEVELS-1:0] i_request,
    input wire logic [N_LEVELS-1:0] i_in_service,
    input wire logic [2:0] i_int_level,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [7:0] o_vector,
    output mpcd_pkg::mpcd_eoi_t o_eoi,
    output logic o_special_mask,
    output logic o_aeoi_rotate,
    output logic o_init_done,
    output logic [7:0] o_first_word,
    output logic [7:0] o_third_word,
    output logic [7:0] o_fourth_word
);

    generate
        if (N_LEVELS != 8)
        begin : g_bad_levels
            $error("mpcd_top serves exactly eight levels");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    mpcd_pkg::mpcd_regs_t st_r;
    mpcd_pkg::mpcd_regs_t st_nxt;
    logic cmd_wr;
    logic cmd_rd;
    logic data_wr;
    logic init_wr;
    logic ocw3_wr;
    logic ocw2_wr;
    logic [7:0] wd;
    logic [7:0] vec_w;
    logic [7:0] poll_byte_w;

    assign wd = i_bus.wdata;
    assign cmd_wr = i_bus.wr && (i_bus.addr == mpcd_pkg::CMD_PORT_ADDR);
    assign data_wr = i_bus.wr && (i_bus.addr == mpcd_pkg::DATA_PORT_ADDR);
    assign cmd_rd = i_bus.rd && (i_bus.addr == mpcd_pkg::CMD_PORT_ADDR);
    assign init_wr = cmd_wr && wd[mpcd_pkg::INIT_SEL_BIT];
    assign ocw3_wr = cmd_wr && !wd[mpcd_pkg::INIT_SEL_BIT] && wd[mpcd_pkg::OCW_SEL_BIT];
    assign ocw2_wr = cmd_wr && !wd[mpcd_pkg::INIT_SEL_BIT] && !wd[mpcd_pkg::OCW_SEL_BIT];

    mpcd_vec_form #(
        .N_LEVELS(N_LEVELS)
    ) u_vec_form (
        .i_vbase(st_r.vbase),
        .i_level(i_int_level),
        .i_request(i_request),
        .o_vector(vec_w),
        .o_poll_byte(poll_byte_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.eoi.valid = 1'b0;
        st_nxt.rvalid = 1'b0;
        st_nxt.vector = vec_w;
        // Reads first, so a write in the same cycle wins over a poll clear
        if (i_bus.rd)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = 8'h00;
            if (cmd_rd)
            begin
                if (st_r.poll)
                begin
                    st_nxt.rdata = poll_byte_w;
                    st_nxt.poll = 1'b0;
                end
                else
                begin
                    st_nxt.rdata = st_r.rsel_isr ? i_in_service : i_request;
                end
            end
        end
        if (init_wr)
        begin
            st_nxt.state = mpcd_pkg::ST_W2;
            st_nxt.init_done = 1'b0;
            st_nxt.first_word = wd;
            st_nxt.special_mask = 1'b0;
            st_nxt.rsel_isr = 1'b0;
            st_nxt.poll = 1'b0;
            st_nxt.aeoi_rotate = 1'b0;
        end
        else if (ocw3_wr)
        begin
            if (wd[mpcd_pkg::SMM_HI:mpcd_pkg::SMM_LO] == mpcd_pkg::SMM_SET)
            begin
                st_nxt.special_mask = 1'b1;
            end
            else if (wd[mpcd_pkg::SMM_HI:mpcd_pkg::SMM_LO] == mpcd_pkg::SMM_CLEAR)
            begin
                st_nxt.special_mask = 1'b0;
            end
            st_nxt.poll = wd[mpcd_pkg::POLL_BIT];
            if (wd[mpcd_pkg::RSEL_HI])
            begin
                st_nxt.rsel_isr = wd[mpcd_pkg::RSEL_LO];
            end
        end
        else if (ocw2_wr)
        begin
            st_nxt.eoi.level = wd[mpcd_pkg::LVL_HI:mpcd_pkg::LVL_LO];
            st_nxt.eoi.nonspec = 1'b0;
            st_nxt.eoi.specific = 1'b0;
            st_nxt.eoi.rotate = 1'b0;
            st_nxt.eoi.set_prio = 1'b0;
            st_nxt.eoi.valid = 1'b1;
            unique case (wd[mpcd_pkg::EOI_HI:mpcd_pkg::EOI_LO])
                mpcd_pkg::EOI_NONSPEC: st_nxt.eoi.nonspec = 1'b1;
                mpcd_pkg::EOI_SPECIFIC: st_nxt.eoi.specific = 1'b1;
                mpcd_pkg::EOI_ROT_NONSPEC:
                begin
                    st_nxt.eoi.nonspec = 1'b1;
                    st_nxt.eoi.rotate = 1'b1;
                end
                mpcd_pkg::EOI_ROT_SPECIFIC:
                begin
                    st_nxt.eoi.specific = 1'b1;
                    st_nxt.eoi.rotate = 1'b1;
                end
                mpcd_pkg::EOI_SET_PRIO: st_nxt.eoi.set_prio = 1'b1;
                mpcd_pkg::EOI_AEOI_ROT_SET:
                begin
                    st_nxt.eoi.valid = 1'b0;
                    st_nxt.aeoi_rotate = 1'b1;
                end
                mpcd_pkg::EOI_AEOI_ROT_CLR:
                begin
                    st_nxt.eoi.valid = 1'b0;
                    st_nxt.aeoi_rotate = 1'b0;
                end
                mpcd_pkg::EOI_NOP: st_nxt.eoi.valid = 1'b0;
            endcase
        end
        // Data port writes outside the init sequence belong to the mask logic
        if (data_wr)
        begin
            unique case (st_r.state)
                mpcd_pkg::ST_W2:
                begin
                    st_nxt.vbase = wd[mpcd_pkg::VBASE_HI:mpcd_pkg::VBASE_LO];
                    if (!st_r.first_word[mpcd_pkg::SINGLE_CONTROLLER_FLAG_BIT])
                    begin
                        st_nxt.state = mpcd_pkg::ST_W3;
                    end
                    else if (st_r.first_word[mpcd_pkg::IC4_BIT])
                    begin
                        st_nxt.state = mpcd_pkg::ST_W4;
                    end
                    else
                    begin
                        st_nxt.state = mpcd_pkg::ST_READY;
                        st_nxt.init_done = 1'b1;
                    end
                end
                mpcd_pkg::ST_W3:
                begin
                    st_nxt.third_word = wd;
                    if (st_r.first_word[mpcd_pkg::IC4_BIT])
                    begin
                        st_nxt.state = mpcd_pkg::ST_W4;
                    end
                    else
                    begin
                        st_nxt.state = mpcd_pkg::ST_READY;
                        st_nxt.init_done = 1'b1;
                    end
                end
                mpcd_pkg::ST_W4:
                begin
                    st_nxt.fourth_word = wd;
                    st_nxt.state = mpcd_pkg::ST_READY;
                    st_nxt.init_done = 1'b1;
                end
                mpcd_pkg::ST_READY:
                begin
                    st_nxt.state = mpcd_pkg::ST_READY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_r <= '{state: mpcd_pkg::ST_READY, init_done: 1'b0, first_word: mpcd_pkg::RST_WORD,
                      vbase: mpcd_pkg::RST_VBASE, third_word: mpcd_pkg::RST_WORD,
                      fourth_word: mpcd_pkg::RST_WORD, special_mask: 1'b0, rsel_isr: 1'b0,
                      poll: 1'b0, aeoi_rotate: 1'b0, eoi: '0, rdata: mpcd_pkg::RST_WORD,
                      rvalid: 1'b0, vector: mpcd_pkg::RST_WORD};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_rvalid = st_r.rvalid;
    assign o_vector = st_r.vector;
    assign o_eoi = st_r.eoi;
    assign o_special_mask = st_r.special_mask;
    assign o_aeoi_rotate = st_r.aeoi_rotate;
    assign o_init_done = st_r.init_done;
    assign o_first_word = st_r.first_word;
    assign o_third_word = st_r.third_word;
    assign o_fourth_word = st_r.fourth_word;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_init_word_take: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        init_wr |=> (st_r.state == mpcd_pkg::ST_W2) && (o_first_word == $past(wd))
            && !o_special_mask && !st_r.poll && !o_init_done)
        else $error("first init word not taken");

    a_smm_control: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        ocw3_wr |=> o_special_mask == ($past(wd[6]) ? $past(wd[5]) : $past(o_special_mask)))
        else $error("special mask mode wrong");

    a_ocw3_no_eoi: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        ocw3_wr |=> !o_eoi.valid && (st_r.poll == $past(wd[2])))
        else $error("mask-and-poll word misrouted");

    a_rsel_keep: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (ocw3_wr && !wd[1]) |=> st_r.rsel_isr == $past(st_r.rsel_isr))
        else $error("read select changed on no-change code");

    a_status_read: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (cmd_rd && !st_r.poll) |=> o_rvalid
            && (o_rdata == ($past(st_r.rsel_isr) ? $past(i_in_service) : $past(i_request))))
        else $error("status read returned wrong register");

    a_poll_read: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (cmd_rd && st_r.poll && !i_bus.wr) |=> o_rvalid && !st_r.poll
            && (o_rdata[7] == |$past(i_request)) && (o_rdata[6:3] == 4'h0))
        else $error("poll read wrong");

    a_eoi_nonspec: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (ocw2_wr && wd[7:5] == 3'h1) |=> o_eoi.valid && o_eoi.nonspec && !o_eoi.rotate
            && (o_eoi.level == $past(wd[2:0])) ##1 (!o_eoi.valid || $past(ocw2_wr)))
        else $error("nonspecific EOI decode wrong");

    a_vector_form: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 o_vector == {$past(st_r.vbase), $past(i_int_level)})
        else $error("vector not formed from base and level");

    a_ptr_skip: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (data_wr && st_r.state == mpcd_pkg::ST_W2) |=> st_r.vbase == $past(wd[7:3])
            && st_r.state == (!$past(st_r.first_word[1]) ? mpcd_pkg::ST_W3 :
                $past(st_r.first_word[0]) ? mpcd_pkg::ST_W4 : mpcd_pkg::ST_READY))
        else $error("init pointer advanced wrongly");

endmodule // mpcd_top

// >>> tb/mpcd_host_model.sv
// Host core model issuing command and data port writes and reads
`timescale 1ns/1ps
module mpcd_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output mpcd_pkg::mpcd_bus_t o_bus
);

    initial o_bus = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Released address and data show their inverse so stale values cannot pass
    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == mpcd_pkg::CMD_PORT_ADDR && d[mpcd_pkg::OCW_SEL_BIT] && !d[mpcd_pkg::INIT_SEL_BIT])
            d[7] = 1'b0;
        @(posedge i_clk);
        o_bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
        #1;
    endtask

    task automatic get(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~o_bus.wdata};
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: o_bus.wdata};
        // The valid pulse stands for one cycle only, so take it just after the answering edge
        #1;
        data = i_rdata;
        vld = i_rvalid;
    endtask

    // Words go out in order, first and vector base always
    task automatic init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3, input logic [7:0] w4);
        put(mpcd_pkg::CMD_PORT_ADDR, w1 | 8'h10);
        put(mpcd_pkg::DATA_PORT_ADDR, {w2[7:3], 3'h0});
        if (!w1[mpcd_pkg::SINGLE_CONTROLLER_FLAG_BIT])
            put(mpcd_pkg::DATA_PORT_ADDR, w3);
        if (w1[mpcd_pkg::IC4_BIT])
            put(mpcd_pkg::DATA_PORT_ADDR, w4);
    endtask

endmodule // mpcd_host_model

// >>> tb/test_master_pic_command_port_decode.sv
// Self-checking bench for the command port decode
`timescale 1ns/1ps
module test_master_pic_command_port_decode;

    localparam logic [7:0] CMD = mpcd_pkg::CMD_PORT_ADDR;
    localparam logic [7:0] DAT = mpcd_pkg::DATA_PORT_ADDR;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    mpcd_pkg::mpcd_bus_t bus;
    logic [7:0] req = 8'h00;
    logic [7:0] isr = 8'h00;
    logic [2:0] lvl = 3'h0;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic [7:0] o_vector;
    mpcd_pkg::mpcd_eoi_t eoi;
    logic o_special_mask;
    logic o_aeoi_rotate;
    logic o_init_done;
    logic [7:0] o_first_word;
    logic [7:0] o_third_word;
    logic [7:0] o_fourth_word;
    logic [7:0] rd;
    logic rv;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 i_clk = ~i_clk;

    mpcd_top #(.N_LEVELS(8)) mpcd_top_inst (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(bus), .i_request(req), .i_in_service(isr),
        .i_int_level(lvl), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_vector(o_vector), .o_eoi(eoi),
        .o_special_mask(o_special_mask), .o_aeoi_rotate(o_aeoi_rotate), .o_init_done(o_init_done),
        .o_first_word(o_first_word), .o_third_word(o_third_word), .o_fourth_word(o_fourth_word)
    );

    mpcd_host_model mpcd_host_model_inst (
        .i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Generous ceiling; the whole run needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        @(posedge i_clk) lvl <= 3'h5;
        mpcd_host_model_inst.put(CMD, 8'h13);
        check("first", o_first_word, 8'h13);
        mpcd_host_model_inst.put(DAT, 8'h08);
        check("done", {7'h0, o_init_done}, 8'h00);
        mpcd_host_model_inst.put(DAT, 8'h5A);
        check("fourth", o_fourth_word, 8'h5A);
        check("done", {7'h0, o_init_done}, 8'h01);
        check("vector", o_vector, 8'h0D);
        mpcd_host_model_inst.put(DAT, 8'hC3);
        check("fourth", o_fourth_word, 8'h5A);
        // Restart in mid-sequence must rewind to the vector base word
        mpcd_host_model_inst.put(CMD, 8'hFC);
        check("done", {7'h0, o_init_done}, 8'h00);
        mpcd_host_model_inst.put(DAT, 8'hF8);
        mpcd_host_model_inst.put(CMD, 8'hFC);
        mpcd_host_model_inst.put(DAT, 8'h70);
        // Vector is registered from the base of the previous cycle
        @(posedge i_clk);
        #1;
        check("vector", o_vector, 8'h75);
        check("done", {7'h0, o_init_done}, 8'h00);
        mpcd_host_model_inst.put(DAT, 8'h44);
        check("third", o_third_word, 8'h44);
        check("done", {7'h0, o_init_done}, 8'h01);
        mpcd_host_model_inst.init(8'h12, 8'h20, 8'h99, 8'h66);
        check("done", {7'h0, o_init_done}, 8'h01);
        @(posedge i_clk);
        #1;
        check("vector", o_vector, 8'h25);
        check("third", o_third_word, 8'h44);
    endtask

    task automatic t_smm();
        logic [1:0] code [5];
        logic sm [5];
        code = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
        sm = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++)
        begin
            mpcd_host_model_inst.put(CMD, {1'b1, code[i], 5'h08});
            check("smask", {7'h0, o_special_mask}, {7'h0, sm[i]});
        end
    endtask

    task automatic t_rsel();
        logic [1:0] code [4];
        logic [7:0] exp [4];
        code = '{2'h3, 2'h1, 2'h2, 2'h0};
        exp = '{8'h3C, 8'h3C, 8'hA5, 8'hA5};
        @(posedge i_clk)
        begin
            req <= 8'hA5;
            isr <= 8'h3C;
        end
        for (int i = 0; i < 4; i++)
        begin
            mpcd_host_model_inst.put(CMD, {6'h02, code[i]});
            repeat (2)
            begin
                mpcd_host_model_inst.get(CMD, rd, rv);
                check("rvalid", {7'h0, rv}, 8'h01);
                check("status", rd, exp[i]);
            end
        end
    endtask

    task automatic t_poll();
        @(posedge i_clk) req <= 8'h28;
        mpcd_host_model_inst.put(CMD, 8'h0C);
        mpcd_host_model_inst.get(CMD, rd, rv);
        check("poll", rd, 8'h83);
        mpcd_host_model_inst.get(CMD, rd, rv);
        check("status", rd, 8'h28);
        @(posedge i_clk) req <= 8'h80;
        mpcd_host_model_inst.put(CMD, 8'h08);
        mpcd_host_model_inst.get(CMD, rd, rv);
        check("nopoll", rd, 8'h80);
        @(posedge i_clk) req <= 8'h00;
        mpcd_host_model_inst.put(CMD, 8'h0C);
        mpcd_host_model_inst.get(CMD, rd, rv);
        check("poll", rd, 8'h00);
    endtask

    task automatic t_eoi();
        logic [2:0] c;
        logic a;
        a = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            mpcd_host_model_inst.put(CMD, {c, 2'h0, ~c});
            a = (c == 3'h4) ? 1'b1 : ((c == 3'h0) ? 1'b0 : a);
            if (c == 3'h2)
                check("eoi_valid", {7'h0, eoi.valid}, 8'h00);
            else
                check("eoi", {eoi.valid, eoi.nonspec, eoi.specific, eoi.rotate, eoi.set_prio, eoi.level},
                    {c != 3'h0 && c != 3'h4, c == 3'h1 || c == 3'h5, c == 3'h3 || c == 3'h7,
                    c == 3'h5 || c == 3'h7, c == 3'h6, ~c});
            check("aeoi", {7'h0, o_aeoi_rotate}, {7'h0, a});
            @(posedge i_clk);
            #1;
            check("eoi_valid", {7'h0, eoi.valid}, 8'h00);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        #1;
        check("done", {7'h0, o_init_done}, 8'h00);
        check("eoi", eoi, 8'h00);
        t_init();
        t_smm();
        t_rsel();
        t_poll();
        t_eoi();
        stop_test();
    end

endmodule // test_master_pic_command_port_decode
